// *** flvm_pkg.sv ***
/*
 * Package for the loop value / multiplier / sync register block: offsets,
 * field layouts, reset values, states and carrier structs.
 * Assumes a plain one-cycle register port on a single 40 MHz clock.
 */
package flvm_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL    = 8'h24;
	localparam logic [7:0] OFS_VALUE      = 8'h28;
	localparam logic [7:0] OFS_MULTIPLIER = 8'h2c;
	localparam logic [7:0] OFS_SYNC       = 8'h30;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h3c;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int MODE_BIT     = 2;
	localparam int FETCH_BIT    = 7;
	localparam int ERR_LSB      = 16;
	localparam int COARSE_LSB   = 10;
	localparam int FINE_LSB     = 0;
	localparam int COARSE_MAX_STEP_LSB    = 26;
	localparam int FINE_MAX_STEP_LSB    = 16;
	localparam int FACTOR_LSB   = 0;
	localparam int IRQ_READY    = 0;
	localparam int IRQ_FACTOR   = 1;
	localparam int IRQ_W        = 2;

	// ------------------------------------------------------------------
	// Reset values and constants
	// ------------------------------------------------------------------
	localparam logic [31:0] VALUE_RST      = 32'h0000_0000;
	localparam logic [31:0] MULTIPLIER_RST = 32'h0000_0000;
	localparam logic [7:0]  SYNC_RST       = 8'h00;
	localparam logic [9:0]  FINE_MID       = 10'h200;
	localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
	// Reference period in system clocks between loop comparisons
	localparam logic [7:0]  REF_DIV_RST    = 8'h20;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} flvm_bus_t;

	typedef struct packed {
		logic [15:0] err;
		logic [5:0]  coarse;
		logic [9:0]  fine;
	} flvm_value_t;

	typedef struct packed {
		logic [5:0]  coarse_max_step;
		logic [9:0]  fine_max_step;
		logic [15:0] factor;
	} flvm_mult_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_COARSE,
		ST_FINE
	} flvm_lock_t;

endpackage : flvm_pkg

// *** flvm_step.sv ***
/*
 * Step limiter: moves a calibration value toward a target by at most a
 * programmed step, saturating at the field range. Result is registered.
 * Assumes the caller holds inputs stable while load_in is high.
 */
`timescale 1ns/100ps
module flvm_step #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         rst_n_in,
	// Operands
	input  wire logic         load_in,
	input  wire logic         up_in,
	input  wire logic [W-1:0] cur_in,
	input  wire logic [W-1:0] max_step_in,
	input  wire logic [W-1:0] want_in,
	// Result
	output logic     [W-1:0]  next_out
);

	initial begin
		if (W < 2 || W > 16) $error("flvm_step: W out of range");
	end

	logic [W-1:0] step;
	logic [W:0]   sum;
	logic [W-1:0] res;

	always_comb begin
		step = (want_in < max_step_in) ? want_in : max_step_in;
		if (up_in) begin
			sum = {1'b0, cur_in} + {1'b0, step};
			res = sum[W] ? {W{1'b1}} : sum[W-1:0];
		end else begin
			sum = {1'b0, cur_in} - {1'b0, step};
			res = sum[W] ? '0 : sum[W-1:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			next_out <= '0;
		end else if (load_in) begin
			next_out <= res;
		end
	end

endmodule : flvm_step

// *** flvm_regs.sv ***
/*
 * Loop value, multiplier and sync registers of a frequency-locked loop,
 * with a simple closed-loop tuner driven by measured cycle counts.
 * Assumes loop_count_in comes from a counter on this clock, pulsed by
 * loop_count_vld_in once per reference period, and a one-cycle reg port.
 */
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module flvm_regs (
	// Clock and reset
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	// Register port
	input  wire flvm_pkg::flvm_bus_t  bus_in,
	output logic              [31:0]  rdata_out,
	// Loop measurement, cycles counted per reference period
	input  wire logic         [15:0]  loop_count_in,
	input  wire logic                 loop_count_vld_in,
	// Oscillator controls
	output logic              [5:0]   coarse_out,
	output logic              [9:0]   fine_out,
	output logic                      closed_loop_out,
	output logic                      loop_ready_flag_out,
	output logic                      locked_out,
	// Interrupt
	output logic                      irq_out
);

	typedef struct packed {
		logic                  mode;
		flvm_pkg::flvm_value_t live;
		flvm_pkg::flvm_value_t snap;
		flvm_pkg::flvm_mult_t  mult;
		flvm_pkg::flvm_lock_t  lock;
		logic                  fetch_pend;
		logic                  ready;
		logic                  step_pend;
		logic                  step_coarse;
		logic [flvm_pkg::IRQ_W-1:0] irq_st;
		logic [flvm_pkg::IRQ_W-1:0] irq_mask;
		logic                  locked;
		logic [31:0]           rdata;
		logic                  irq;
	} flvm_state_t;

	flvm_state_t s_q;
	flvm_state_t s_d;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// Value and multiplier words are read back as whole structs, so the
	// field positions must match the struct packing exactly.
	initial begin
		if ($bits(flvm_pkg::flvm_value_t) != 32) begin
			$error("flvm_regs: value word is not 32 bits");
		end
		if ($bits(flvm_pkg::flvm_mult_t) != 32) begin
			$error("flvm_regs: multiplier word is not 32 bits");
		end
		if (flvm_pkg::FINE_LSB + 10 != flvm_pkg::COARSE_LSB) begin
			$error("flvm_regs: fine field does not meet coarse field");
		end
		if (flvm_pkg::COARSE_LSB + 6 != flvm_pkg::ERR_LSB) begin
			$error("flvm_regs: coarse field does not meet error field");
		end
		if (flvm_pkg::ERR_LSB + 16 != 32) begin
			$error("flvm_regs: error field does not end at bit 31");
		end
		if (flvm_pkg::FACTOR_LSB + 16 != flvm_pkg::FINE_MAX_STEP_LSB) begin
			$error("flvm_regs: factor field does not meet fine step");
		end
		if (flvm_pkg::FINE_MAX_STEP_LSB + 10 != flvm_pkg::COARSE_MAX_STEP_LSB) begin
			$error("flvm_regs: fine step does not meet coarse step");
		end
		if (flvm_pkg::COARSE_MAX_STEP_LSB + 6 != 32) begin
			$error("flvm_regs: coarse step does not end at bit 31");
		end
		if (int'(flvm_pkg::FINE_MID) * 2 != 1024) begin
			$error("flvm_regs: fine midpoint is not half the range");
		end
		if (flvm_pkg::MODE_BIT > 31) begin
			$error("flvm_regs: mode bit outside the control word");
		end
		if (flvm_pkg::FETCH_BIT > 7) begin
			$error("flvm_regs: fetch bit outside the sync register");
		end
		if (flvm_pkg::IRQ_READY >= flvm_pkg::IRQ_W) begin
			$error("flvm_regs: ready event bit outside status");
		end
		if (flvm_pkg::IRQ_FACTOR >= flvm_pkg::IRQ_W) begin
			$error("flvm_regs: factor event bit outside status");
		end
		if (flvm_pkg::IRQ_READY == flvm_pkg::IRQ_FACTOR) begin
			$error("flvm_regs: status events share one bit");
		end
	end

	// ------------------------------------------------------------------
	// Error computation and step limiters
	// ------------------------------------------------------------------
	logic [15:0] err_now;
	logic        err_up;
	logic [15:0] err_mag;
	logic [5:0]  coarse_nx;
	logic [9:0]  fine_nx;

	// A count above the factor wraps to a negative error; the sign bit
	// then steers both limiters downward.
	assign err_now = s_q.mult.factor - loop_count_in;
	assign err_up  = ~err_now[15];
	assign err_mag = err_now[15] ? 16'(-err_now) : err_now;

	// Limiters register their result: a step lands two cycles after the
	// count pulse, and step_pend carries the cycle in between.
	flvm_step #(.W(6)) u_coarse (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (loop_count_vld_in),
		.up_in       (err_up),
		.cur_in      (s_q.live.coarse),
		.max_step_in (s_q.mult.coarse_max_step),
		.want_in     ((|err_mag[15:6]) ? 6'h3f : err_mag[5:0]),
		.next_out    (coarse_nx)
	);

	flvm_step #(.W(10)) u_fine (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (loop_count_vld_in),
		.up_in       (err_up),
		.cur_in      (s_q.live.fine),
		.max_step_in (s_q.mult.fine_max_step),
		.want_in     ((|err_mag[15:10]) ? 10'h3ff : err_mag[9:0]),
		.next_out    (fine_nx)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	logic        wr_val;
	logic        wr_mul;
	logic        wr_ctl;
	logic        wr_sync;
	logic        wr_mask;
	logic        rd_stat;
	logic [flvm_pkg::IRQ_W-1:0] ev;

	always_comb begin
		s_d = s_q;
		ev  = '0;
		wr_ctl  = bus_in.wr && bus_in.addr == flvm_pkg::OFS_CONTROL;
		wr_val  = bus_in.wr && bus_in.addr == flvm_pkg::OFS_VALUE;
		wr_mul  = bus_in.wr && bus_in.addr == flvm_pkg::OFS_MULTIPLIER;
		wr_sync = bus_in.wr && bus_in.addr == flvm_pkg::OFS_SYNC;
		wr_mask = bus_in.wr && bus_in.addr == flvm_pkg::OFS_IRQ_MASK;
		rd_stat = bus_in.rd && bus_in.addr == flvm_pkg::OFS_IRQ_STATUS;

		// ----------------------------------------------------------
		// Register writes
		// ----------------------------------------------------------
		if (wr_ctl) begin
			s_d.mode = bus_in.wdata[flvm_pkg::MODE_BIT];
		end
		// Only direct value writes are refused in closed loop; a factor
		// write may still centre the fine value.
		if (wr_val && !s_q.mode) begin
			s_d.live.coarse = bus_in.wdata[flvm_pkg::COARSE_LSB +: 6];
			s_d.live.fine   = bus_in.wdata[flvm_pkg::FINE_LSB +: 10];
		end
		if (wr_mask) begin
			s_d.irq_mask = bus_in.wdata[flvm_pkg::IRQ_W-1:0];
		end

		// ----------------------------------------------------------
		// Closed-loop tuning: measure, then apply the limited step
		// ----------------------------------------------------------
		s_d.step_pend = 1'b0;
		if (s_q.mode && loop_count_vld_in) begin
			s_d.live.err  = err_now;
			s_d.step_pend = 1'b1;
			if (s_q.lock == flvm_pkg::ST_IDLE) begin
				s_d.lock = flvm_pkg::ST_COARSE;
			end
			s_d.step_coarse = s_q.lock != flvm_pkg::ST_FINE;
		end
		if (s_q.mode && s_q.step_pend) begin
			if (s_q.step_coarse) begin
				s_d.live.coarse = coarse_nx;
				if (s_q.live.err == 16'h0000 ||
				    coarse_nx == s_q.live.coarse) begin
					s_d.lock = flvm_pkg::ST_FINE;
				end
			end else begin
				s_d.live.fine = fine_nx;
			end
		end
		if (!s_q.mode) begin
			s_d.lock = flvm_pkg::ST_IDLE;
		end

		// ----------------------------------------------------------
		// Factor write: restart the lock search from the midpoint
		// ----------------------------------------------------------
		if (wr_mul) begin
			s_d.mult.coarse_max_step  = bus_in.wdata[flvm_pkg::COARSE_MAX_STEP_LSB +: 6];
			s_d.mult.fine_max_step  = bus_in.wdata[flvm_pkg::FINE_MAX_STEP_LSB +: 10];
			s_d.mult.factor = bus_in.wdata[flvm_pkg::FACTOR_LSB +: 16];
			s_d.lock        = flvm_pkg::ST_IDLE;
			s_d.live.fine   = flvm_pkg::FINE_MID;
			s_d.step_pend   = 1'b0;
			ev[flvm_pkg::IRQ_FACTOR] = 1'b1;
		end

		// ----------------------------------------------------------
		// Value fetch: snapshot first, ready flag the cycle after
		// ----------------------------------------------------------
		s_d.ready = s_q.ready;
		if (wr_sync && bus_in.wdata[flvm_pkg::FETCH_BIT]) begin
			s_d.fetch_pend = 1'b1;
			s_d.ready      = 1'b0;
		end else if (s_q.fetch_pend) begin
			s_d.snap       = s_q.live;
			s_d.fetch_pend = 1'b0;
		end else if (!s_q.ready && !s_q.fetch_pend) begin
			s_d.ready = 1'b1;
			ev[flvm_pkg::IRQ_READY] = 1'b1;
		end
		// In open loop the snapshot follows the live value
		if (!s_q.mode && !s_q.fetch_pend) begin
			s_d.snap = s_d.live;
		end

		// ----------------------------------------------------------
		// Sticky status: read clears, a new event wins
		// ----------------------------------------------------------
		if (rd_stat) begin
			s_d.irq_st = '0;
		end
		s_d.irq_st = s_d.irq_st | ev;

		// ----------------------------------------------------------
		// Read data, valid in the cycle after the strobe
		// ----------------------------------------------------------
		s_d.rdata = 32'h0000_0000;
		if (bus_in.rd) begin
			case (bus_in.addr)
				flvm_pkg::OFS_CONTROL:
					s_d.rdata[flvm_pkg::MODE_BIT] = s_q.mode;
				flvm_pkg::OFS_VALUE:
					s_d.rdata = s_q.snap;
				flvm_pkg::OFS_MULTIPLIER:
					s_d.rdata = s_q.mult;
				flvm_pkg::OFS_SYNC:
					s_d.rdata = 32'h0000_0000;
				flvm_pkg::OFS_IRQ_STATUS:
					s_d.rdata[flvm_pkg::IRQ_W-1:0] = s_q.irq_st;
				flvm_pkg::OFS_IRQ_MASK:
					s_d.rdata[flvm_pkg::IRQ_W-1:0] = s_q.irq_mask;
				default:
					s_d.rdata = 32'h0000_0000;
			endcase
		end
		s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
		s_d.locked = s_d.lock == flvm_pkg::ST_FINE;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			s_q            <= '0;
			s_q.live       <= flvm_pkg::VALUE_RST;
			s_q.snap       <= flvm_pkg::VALUE_RST;
			s_q.mult       <= flvm_pkg::MULTIPLIER_RST;
			s_q.lock       <= flvm_pkg::ST_IDLE;
			s_q.ready      <= 1'b1;
			s_q.irq_mask   <= flvm_pkg::IRQ_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata_out           = s_q.rdata;
	assign coarse_out          = s_q.live.coarse;
	assign fine_out            = s_q.live.fine;
	assign closed_loop_out     = s_q.mode;
	assign loop_ready_flag_out = s_q.ready;
	assign locked_out          = s_q.locked;
	assign irq_out             = s_q.irq;

endmodule : flvm_regs

// *** flvm_properties.sv ***
/* Port checker for flvm_regs.
 * Assumes binding to every flvm_regs instance on one clock. */
`timescale 1ns/100ps
module flvm_properties (
	input wire logic                core_clk_in,
	input wire logic                rst_n_in,
	input wire flvm_pkg::flvm_bus_t bus_in,
	input wire logic         [31:0] rdata_out,
	input wire logic         [5:0]  coarse_out,
	input wire logic         [9:0]  fine_out,
	input wire logic                closed_loop_out,
	input wire logic                loop_ready_flag_out,
	input wire logic                locked_out,
	input wire logic                loop_count_vld_in
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [5:0] coarse_max_step_q;
	logic [9:0] fine_max_step_q;
	wire        wr_mul = bus_in.wr && bus_in.addr == flvm_pkg::OFS_MULTIPLIER;
	// Shadow of the step limits
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			coarse_max_step_q <= '0;
			fine_max_step_q <= '0;
		end else if (wr_mul) begin
			coarse_max_step_q <= bus_in.wdata[flvm_pkg::COARSE_MAX_STEP_LSB +: 6];
			fine_max_step_q <= bus_in.wdata[flvm_pkg::FINE_MAX_STEP_LSB +: 10];
		end
	end
	sequence s_fetch_req;
		bus_in.wr && bus_in.addr == flvm_pkg::OFS_SYNC
			&& bus_in.wdata[flvm_pkg::FETCH_BIT];
	endsequence
	sequence s_fetch_done;
		!loop_ready_flag_out ##2 loop_ready_flag_out;
	endsequence
	property p_fetch;
		s_fetch_req |=> s_fetch_done;
	endproperty
	property p_mode;
		$past(bus_in.wr && bus_in.addr == flvm_pkg::OFS_CONTROL)
			|-> closed_loop_out == $past(bus_in.wdata[flvm_pkg::MODE_BIT]);
	endproperty
	property p_sync_rd;
		$past(bus_in.rd && bus_in.addr == flvm_pkg::OFS_SYNC)
			|-> rdata_out == 32'h0;
	endproperty
	property p_mid;
		$past(wr_mul) |-> fine_out == flvm_pkg::FINE_MID;
	endproperty
	property p_unlock;
		wr_mul |=> !locked_out;
	endproperty
	property p_freeze;
		closed_loop_out && bus_in.wr && bus_in.addr == flvm_pkg::OFS_VALUE
			&& !loop_count_vld_in && !$past(loop_count_vld_in)
			|=> $stable(coarse_out) && $stable(fine_out);
	endproperty
	property p_coarse_step;
		closed_loop_out && $past(closed_loop_out) |->
			(coarse_out >= $past(coarse_out) ? coarse_out - $past(coarse_out)
			: $past(coarse_out) - coarse_out) <= coarse_max_step_q;
	endproperty
	property p_fine_step;
		closed_loop_out && $past(closed_loop_out) && !$past(wr_mul) |->
			(fine_out >= $past(fine_out) ? fine_out - $past(fine_out)
			: $past(fine_out) - fine_out) <= fine_max_step_q;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch ready timing wrong");
	a_mode: assert property (p_mode)
		else $error("mode bit not taken");
	a_sync_rd: assert property (p_sync_rd)
		else $error("sync register read not zero");
	a_mid: assert property (p_mid)
		else $error("fine not at midpoint");
	a_unlock: assert property (p_unlock)
		else $error("lock kept after factor write");
	a_freeze: assert property (p_freeze)
		else $error("value write took effect in closed loop");
	a_coarse_step: assert property (p_coarse_step)
		else $error("coarse step too large");
	a_fine_step: assert property (p_fine_step)
		else $error("fine step too large");
endmodule : flvm_properties

bind flvm_regs flvm_properties flvm_properties_inst (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
	.rdata_out(rdata_out), .coarse_out(coarse_out), .fine_out(fine_out),
	.closed_loop_out(closed_loop_out), .locked_out(locked_out),
	.loop_ready_flag_out(loop_ready_flag_out),
	.loop_count_vld_in(loop_count_vld_in)
);

// *** testbench.sv ***
/* Self-checking bench for flvm_regs.
 * Assumes flvm_pkg and the bound checker are compiled first. */
`timescale 1ns/100ps
module testbench;
	logic                core_clk_in = 1'b0;
	logic                rst_n_in    = 1'b0;
	flvm_pkg::flvm_bus_t bus         = '0;
	logic         [15:0] cnt         = 16'h0;
	logic                vld         = 1'b0;
	logic         [31:0] rdata;
	logic         [5:0]  coarse;
	logic         [9:0]  fine;
	logic                closed, ready, locked, irq;
	int                  fail_count  = 0;
	int                  comparisons = 0;
	int                  seed        = 671;
	logic         [31:0] exp_q[$];
	logic         [31:0] msk_q[$];
	logic                rd_pend     = 1'b0;
	logic         [31:0] v, m;
	logic         [15:0] fac, c, r;
	logic         [9:0]  f;

	always #12.5 core_clk_in = ~core_clk_in;

	flvm_regs flvm_regs_inst (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
		.rdata_out(rdata), .loop_count_in(cnt), .loop_count_vld_in(vld),
		.coarse_out(coarse), .fine_out(fine), .closed_loop_out(closed),
		.loop_ready_flag_out(ready), .locked_out(locked), .irq_out(irq)
	);

	task automatic check(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge core_clk_in);
		bus.wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, k);
		@(posedge core_clk_in);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		exp_q.push_back(e & k);
		msk_q.push_back(k);
		@(posedge core_clk_in);
		bus.rd   <= 1'b0;
	endtask : rd

	task automatic pulse(input logic [15:0] n);
		@(posedge core_clk_in);
		cnt <= n;
		vld <= 1'b1;
		@(posedge core_clk_in);
		vld <= 1'b0;
		repeat (3) @(posedge core_clk_in);
	endtask : pulse

	task automatic fetch;
		wr(flvm_pkg::OFS_SYNC, 32'h0000_0080);
		@(posedge core_clk_in) #1;
		for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge core_clk_in) #1;
		check("ready", 32'(ready), 32'h1);
	endtask : fetch

	task automatic close_out;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	always @(posedge core_clk_in) begin
		if (rd_pend) begin
			m = msk_q.pop_front();
			check("rdata", rdata & m, exp_q.pop_front());
		end
		rd_pend = bus.rd;
	end

	initial begin
		#(25 * 4000);
		fail_count++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		rd(flvm_pkg::OFS_VALUE, 32'h0, '1);
		rd(flvm_pkg::OFS_MULTIPLIER, 32'h0, '1);
		rd(8'h10, 32'h0, '1);
		// Open loop: value writable, error stays clear
		v = $random(seed);
		wr(flvm_pkg::OFS_VALUE, v);
		fetch();
		rd(flvm_pkg::OFS_VALUE, {16'h0, v[15:0]}, '1);
		check("coarse", 32'(coarse), 32'(v[15:10]));
		rd(flvm_pkg::OFS_SYNC, 32'h0, '1);
		rd(flvm_pkg::OFS_IRQ_STATUS, 32'h0000_0001, '1);
		// Factor write: midpoint, masked then unmasked interrupt
		fac = $random(seed);
		wr(flvm_pkg::OFS_MULTIPLIER, {6'h02, 10'h003, fac});
		@(posedge core_clk_in) #1;
		check("fine", 32'(fine), 32'(flvm_pkg::FINE_MID));
		check("irq", 32'(irq), 32'h0);
		rd(flvm_pkg::OFS_MULTIPLIER, {6'h02, 10'h003, fac}, '1);
		wr(flvm_pkg::OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge core_clk_in) #1;
		check("irq", 32'(irq), 32'h1);
		rd(flvm_pkg::OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
		repeat (2) @(posedge core_clk_in) #1;
		check("irq", 32'(irq), 32'h0);
		// Closed loop: value writes ignored, error reported then frozen
		wr(flvm_pkg::OFS_CONTROL, 32'h0000_0004);
		rd(flvm_pkg::OFS_CONTROL, 32'h0000_0004, '1);
		check("closed", 32'(closed), 32'h1);
		wr(flvm_pkg::OFS_VALUE, ~v);
		@(posedge core_clk_in) #1;
		check("coarse", 32'(coarse), 32'(v[15:10]));
		// Zero error ends the coarse stage without moving coarse
		pulse(fac);
		check("locked", 32'(locked), 32'h1);
		f = flvm_pkg::FINE_MID;
		repeat (4) begin
			r = 16'($random(seed) & 7);
			c = fac - r - 16'h0001;
			f = f + ((r < 16'h0002) ? 10'(r) + 10'h001 : 10'h003);
			pulse(c);
		end
		check("fine", 32'(fine), 32'(f));
		fetch();
		rd(flvm_pkg::OFS_VALUE, {fac - c, 16'h0}, 32'hffff_0000);
		wr(flvm_pkg::OFS_MULTIPLIER, {6'h02, 10'h003, fac});
		@(posedge core_clk_in) #1;
		check("locked", 32'(locked), 32'h0);
		check("fine", 32'(fine), 32'(flvm_pkg::FINE_MID));
		wr(flvm_pkg::OFS_CONTROL, 32'h0);
		pulse(fac);
		fetch();
		rd(flvm_pkg::OFS_VALUE, {fac - c, 16'h0}, 32'hffff_0000);
		repeat (2) @(posedge core_clk_in);
		close_out();
	end
endmodule : testbench
